// *** include/ddrcke_pkg.sv ***
// Constants, commands and states of the DDR3 power-state and init sequencer
package ddrcke_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CK_DIV = 8;
  localparam int unsigned CK_HALF = CK_DIV / 2;
  localparam int unsigned TCK_NS = CK_DIV * CLK_PERIOD_NS;
  localparam int unsigned T_RST_US = 200;
  localparam int unsigned T_INIT_US = 500;
  localparam int unsigned T_CKE_SETUP_NS = 10;
  localparam int unsigned CKE_SETUP_CYC = (T_CKE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_CLK_STABLE_NS = 10;
  localparam int unsigned CLK_STABLE_CK = 5;
  localparam int unsigned TCKE_CK = 3;
  localparam int unsigned XS_CK = 48;
  localparam int unsigned XPR_CK = (XS_CK > 5) ? XS_CK : 5;
  localparam int unsigned XSDLL_CK = 512;
  localparam int unsigned XP_CK = 3;
  localparam int unsigned MRD_CK = 4;
  localparam int unsigned MOD_CK = 12;
  localparam int unsigned DLLK_CK = 512;
  localparam int unsigned ZQINIT_CK = 512;
  localparam int unsigned INIT_END_CK = (DLLK_CK > ZQINIT_CK) ? DLLK_CK : ZQINIT_CK;
  localparam int unsigned SRX_WR_CK = 512;
  localparam int unsigned T_WR_NS = 15;
  localparam int unsigned WR_MIN_CK = (T_WR_NS + TCK_NS - 1) / TCK_NS;
  localparam int unsigned CKE_AGE_MIN = (TCKE_CK - 1) * CK_DIV;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_MR01 = 8'h08;
  localparam logic [7:0] REG_MR23 = 8'h0c;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MR01_RST = 32'h0000_0320;
  localparam logic [31:0] MR23_RST = 32'h0000_0000;
  localparam int unsigned CTRL_PD_BIT = 0;
  localparam int unsigned CTRL_SR_BIT = 1;
  localparam int unsigned CTRL_ODT_BIT = 2;
  // Command codes as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_DES = 4'hf;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_ZQCL = 4'h6;
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  localparam logic [2:0] BA_MR3 = 3'h3;
  localparam int unsigned A_DLL_EN = 0;
  localparam int unsigned A_DLL_RST = 8;
  localparam int unsigned A_ZQ_LONG = 10;
  localparam int unsigned A_RSVD = 13;
  typedef enum logic [3:0] {
    S_RST = 4'h0, S_WAIT = 4'h1, S_CKE = 4'h2, S_XPR = 4'h3,
    S_MR2 = 4'h4, S_MR3 = 4'h5, S_MR1 = 4'h6, S_MR0 = 4'h7,
    S_ZQ = 4'h8, S_IDLE = 4'h9, S_PD = 4'ha, S_SR = 4'hb, S_XIT = 4'hc
  } ddrcke_state_t;
endpackage

// *** rtl/ddrcke_regs.sv ***
// Wishbone classic register file of the DDR3 power-state sequencer
`timescale 1ns/1ps
module ddrcke_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] stat_i,
  output logic [31:0] ctrl_o,
  output logic [31:0] mr01_o,
  output logic [31:0] mr23_o
);
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] ctrl_q;
  logic [31:0] mr01_q;
  logic [31:0] mr23_q;
  logic req_w;

  // One-hot select: bit0 ctrl, bit1 stat, bit2 mr01, bit3 mr23, zero if unmapped
  function automatic logic [3:0] reg_sel(input logic [7:0] adr);
    case (adr)
      ddrcke_pkg::REG_CTRL: reg_sel = 4'h1;
      ddrcke_pkg::REG_STAT: reg_sel = 4'h2;
      ddrcke_pkg::REG_MR01: reg_sel = 4'h4;
      ddrcke_pkg::REG_MR23: reg_sel = 4'h8;
      default: reg_sel = 4'h0;
    endcase
  endfunction

  assign req_w = wb_cyc_i & wb_stb_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_w & ~ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req_w && !ack_q) begin
      case (reg_sel(wb_adr_i))
        4'h1: dat_q <= ctrl_q;
        4'h2: dat_q <= stat_i;
        4'h4: dat_q <= mr01_q;
        4'h8: dat_q <= mr23_q;
        default: dat_q <= 32'h0000_0000;
      endcase
    end
  end

  // Writes land on the edge where the master sees ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= ddrcke_pkg::CTRL_RST;
      mr01_q <= ddrcke_pkg::MR01_RST;
      mr23_q <= ddrcke_pkg::MR23_RST;
    end else if (req_w && wb_we_i && ack_q) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          if (reg_sel(wb_adr_i) == 4'h1) ctrl_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
          if (reg_sel(wb_adr_i) == 4'h4) mr01_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
          if (reg_sel(wb_adr_i) == 4'h8) mr23_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign ctrl_o = ctrl_q;
  assign mr01_o = mr01_q;
  assign mr23_o = mr23_q;
endmodule

// *** rtl/ddrcke_ctrl.sv ***
// DDR3 reset, initialization, power-down and self-refresh sequencer
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
// How it works
// - Only NOP or deselect while CKE toggles, except REFRESH at self-refresh entry
// - Self-refresh entry is REFRESH with CKE falling
// - No self-refresh entry during reads or writes
// - Hold CKE level for minimum pulse time
// - Self-refresh exit: NOP or deselect for exit time, delayed reads
// - Writes wait 512 clocks after self-refresh exit
// - Idle needs banks closed, CKE high, timers expired
// - Reset held 200 us, CKE low before release
// - Wait 500 us after reset before CKE
// - Clock stable and NOP before CKE rises
// - CKE stays high until initialization ends
// - ODT held static low during initialization
// - Wait reset CKE exit time before first MRS
// - Load MR2, MR3, then MR1 with DLL on
// - Then MR0 with DLL reset bit set
// - Long ZQ calibration, wait DLL lock and ZQ
// - MR0 write with reserved bits zero
// - Write recovery field not below the minimum
module ddrcke_ctrl #(
  parameter int unsigned RST_CYC = ddrcke_pkg::T_RST_US * 1000 / ddrcke_pkg::CLK_PERIOD_NS,
  parameter int unsigned WAIT_CYC = ddrcke_pkg::T_INIT_US * 1000 / ddrcke_pkg::CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic banks_idle_i,
  input wire logic burst_busy_i,
  input wire logic ref_due_i,
  output logic ck_o,
  output logic reset_n_o,
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [2:0] ba_o,
  output logic [13:0] addr_o,
  output logic odt_o,
  output logic init_done_o,
  output logic idle_o
);
  ddrcke_pkg::ddrcke_state_t st_q;
  logic [31:0] timer_q;
  logic [2:0] ck_cnt_q;
  logic [2:0] ck_next_w;
  logic ck_q;
  logic step_w;
  logic cke_q;
  logic cke_prev_q;
  logic reset_n_q;
  logic odt_q;
  logic [3:0] cmd_q;
  logic [2:0] ba_q;
  logic [13:0] addr_q;
  logic init_done_q;
  logic pd_act_q;
  logic srx_pulse_q;
  logic [15:0] cke_age_q;
  logic [31:0] dll_cnt_q;
  logic [31:0] wr_cnt_q;
  logic rd_ok_w;
  logic wr_ok_w;
  logic hold_ok_w;
  logic idle_w;
  logic wr_clamp_w;
  logic [31:0] ctrl_w;
  logic [31:0] mr01_w;
  logic [31:0] mr23_w;
  logic [31:0] stat_w;
  logic [13:0] mr0_w;
  logic [13:0] mr1_w;
  logic [31:0] rst_low_q;
  logic [31:0] post_rst_q;
  logic [2:0] last_mr_q;

  // Write recovery in clocks for a given MR0 code
  function automatic logic [4:0] wr_cycles(input logic [2:0] code);
    case (code)
      3'h0: wr_cycles = 5'h10;
      3'h1: wr_cycles = 5'h05;
      3'h2: wr_cycles = 5'h06;
      3'h3: wr_cycles = 5'h07;
      3'h4: wr_cycles = 5'h08;
      3'h5: wr_cycles = 5'h0a;
      3'h6: wr_cycles = 5'h0c;
      default: wr_cycles = 5'h0e;
    endcase
  endfunction

  ddrcke_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .stat_i(stat_w),
    .ctrl_o(ctrl_w),
    .mr01_o(mr01_w),
    .mr23_o(mr23_w)
  );

  // Too short a write recovery is replaced by the longest code
  assign wr_clamp_w = wr_cycles(mr01_w[11:9]) < 5'(ddrcke_pkg::WR_MIN_CK);
  always_comb begin
    mr0_w = mr01_w[13:0];
    if (wr_clamp_w) begin
      mr0_w[11:9] = 3'h0;
    end
    mr0_w[ddrcke_pkg::A_DLL_RST] = 1'b1;
    mr0_w[ddrcke_pkg::A_RSVD] = 1'b0;
    mr1_w = mr01_w[29:16];
    mr1_w[ddrcke_pkg::A_DLL_EN] = 1'b0;
  end

  // CK divider; pins change on the CK falling edge, centred for the device
  assign ck_next_w = (ck_cnt_q == 3'(ddrcke_pkg::CK_DIV - 1)) ? 3'h0 : ck_cnt_q + 3'h1;
  assign step_w = (ck_cnt_q == 3'(ddrcke_pkg::CK_HALF - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ck_cnt_q <= 3'h0;
      ck_q <= 1'b0;
    end else begin
      ck_cnt_q <= ck_next_w;
      ck_q <= (ck_next_w < 3'(ddrcke_pkg::CK_HALF));
    end
  end

  // Clocks since CKE last changed, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cke_prev_q <= 1'b0;
      cke_age_q <= 16'hffff;
    end else begin
      cke_prev_q <= cke_q;
      if (cke_q != cke_prev_q) begin
        cke_age_q <= 16'h0001;
      end else if (cke_age_q != 16'hffff) begin
        cke_age_q <= cke_age_q + 16'h0001;
      end
    end
  end

  assign hold_ok_w = (cke_q == cke_prev_q) &&
                     (32'(cke_age_q) >= ddrcke_pkg::CKE_AGE_MIN - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ddrcke_pkg::S_RST;
      timer_q <= RST_CYC;
      reset_n_q <= 1'b0;
      cke_q <= 1'b0;
      cmd_q <= ddrcke_pkg::CMD_DES;
      ba_q <= 3'h0;
      addr_q <= 14'h0000;
      init_done_q <= 1'b0;
      pd_act_q <= 1'b0;
      srx_pulse_q <= 1'b0;
    end else begin
      srx_pulse_q <= 1'b0;
      if (timer_q != 32'h0000_0000) begin
        timer_q <= timer_q - 32'h0000_0001;
      end
      if (step_w) begin
        cmd_q <= ddrcke_pkg::CMD_DES;
        if (timer_q == 32'h0000_0000) begin
          case (st_q)
            ddrcke_pkg::S_RST: begin
              reset_n_q <= 1'b1;
              timer_q <= WAIT_CYC;
              st_q <= ddrcke_pkg::S_WAIT;
            end
            ddrcke_pkg::S_WAIT: begin
              cmd_q <= ddrcke_pkg::CMD_NOP;
              timer_q <= 32'(ddrcke_pkg::CK_DIV);
              st_q <= ddrcke_pkg::S_CKE;
            end
            ddrcke_pkg::S_CKE: begin
              cke_q <= 1'b1;
              cmd_q <= ddrcke_pkg::CMD_NOP;
              timer_q <= 32'(ddrcke_pkg::XPR_CK * ddrcke_pkg::CK_DIV);
              st_q <= ddrcke_pkg::S_XPR;
            end
            ddrcke_pkg::S_XPR: begin
              cmd_q <= ddrcke_pkg::CMD_MRS;
              ba_q <= ddrcke_pkg::BA_MR2;
              addr_q <= mr23_w[13:0];
              timer_q <= 32'(ddrcke_pkg::MRD_CK * ddrcke_pkg::CK_DIV);
              st_q <= ddrcke_pkg::S_MR2;
            end
            ddrcke_pkg::S_MR2: begin
              cmd_q <= ddrcke_pkg::CMD_MRS;
              ba_q <= ddrcke_pkg::BA_MR3;
              addr_q <= mr23_w[29:16];
              timer_q <= 32'(ddrcke_pkg::MRD_CK * ddrcke_pkg::CK_DIV);
              st_q <= ddrcke_pkg::S_MR3;
            end
            ddrcke_pkg::S_MR3: begin
              cmd_q <= ddrcke_pkg::CMD_MRS;
              ba_q <= ddrcke_pkg::BA_MR1;
              addr_q <= mr1_w;
              timer_q <= 32'(ddrcke_pkg::MRD_CK * ddrcke_pkg::CK_DIV);
              st_q <= ddrcke_pkg::S_MR1;
            end
            ddrcke_pkg::S_MR1: begin
              cmd_q <= ddrcke_pkg::CMD_MRS;
              ba_q <= ddrcke_pkg::BA_MR0;
              addr_q <= mr0_w;
              timer_q <= 32'(ddrcke_pkg::MOD_CK * ddrcke_pkg::CK_DIV);
              st_q <= ddrcke_pkg::S_MR0;
            end
            ddrcke_pkg::S_MR0: begin
              cmd_q <= ddrcke_pkg::CMD_ZQCL;
              ba_q <= 3'h0;
              addr_q <= 14'h0000;
              addr_q[ddrcke_pkg::A_ZQ_LONG] <= 1'b1;
              timer_q <= 32'(ddrcke_pkg::INIT_END_CK * ddrcke_pkg::CK_DIV);
              st_q <= ddrcke_pkg::S_ZQ;
            end
            ddrcke_pkg::S_ZQ: begin
              init_done_q <= 1'b1;
              st_q <= ddrcke_pkg::S_IDLE;
            end
            ddrcke_pkg::S_IDLE: begin
              if (ctrl_w[ddrcke_pkg::CTRL_SR_BIT] && banks_idle_i && !burst_busy_i &&
                  hold_ok_w) begin
                cke_q <= 1'b0;
                cmd_q <= ddrcke_pkg::CMD_REF;
                st_q <= ddrcke_pkg::S_SR;
              end else if (ctrl_w[ddrcke_pkg::CTRL_PD_BIT] && !ref_due_i && hold_ok_w) begin
                cke_q <= 1'b0;
                pd_act_q <= !banks_idle_i;
                st_q <= ddrcke_pkg::S_PD;
              end
            end
            ddrcke_pkg::S_PD: begin
              if ((!ctrl_w[ddrcke_pkg::CTRL_PD_BIT] || ref_due_i) && hold_ok_w) begin
                cke_q <= 1'b1;
                cmd_q <= ddrcke_pkg::CMD_NOP;
                timer_q <= 32'(ddrcke_pkg::XP_CK * ddrcke_pkg::CK_DIV);
                st_q <= ddrcke_pkg::S_XIT;
              end
            end
            ddrcke_pkg::S_SR: begin
              if (!ctrl_w[ddrcke_pkg::CTRL_SR_BIT] && hold_ok_w) begin
                cke_q <= 1'b1;
                cmd_q <= ddrcke_pkg::CMD_NOP;
                srx_pulse_q <= 1'b1;
                timer_q <= 32'(ddrcke_pkg::XS_CK * ddrcke_pkg::CK_DIV);
                st_q <= ddrcke_pkg::S_XIT;
              end
            end
            ddrcke_pkg::S_XIT: begin
              pd_act_q <= 1'b0;
              st_q <= ddrcke_pkg::S_IDLE;
            end
            default: st_q <= ddrcke_pkg::S_RST;
          endcase
        end
      end
    end
  end

  // Reads and synchronous ODT wait for DLL relock after self-refresh exit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dll_cnt_q <= 32'h0000_0000;
    end else if (srx_pulse_q) begin
      dll_cnt_q <= 32'(ddrcke_pkg::XSDLL_CK * ddrcke_pkg::CK_DIV);
    end else if (dll_cnt_q != 32'h0000_0000) begin
      dll_cnt_q <= dll_cnt_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_cnt_q <= 32'h0000_0000;
    end else if (srx_pulse_q) begin
      wr_cnt_q <= 32'(ddrcke_pkg::SRX_WR_CK * ddrcke_pkg::CK_DIV);
    end else if (wr_cnt_q != 32'h0000_0000) begin
      wr_cnt_q <= wr_cnt_q - 32'h0000_0001;
    end
  end

  assign rd_ok_w = init_done_q && cke_q && (dll_cnt_q == 32'h0000_0000) && !srx_pulse_q;
  assign wr_ok_w = init_done_q && cke_q && (wr_cnt_q == 32'h0000_0000) && !srx_pulse_q;
  assign idle_w = (st_q == ddrcke_pkg::S_IDLE) && cke_q && (timer_q == 32'h0000_0000) &&
                  banks_idle_i && !burst_busy_i;

  // ODT stays low through init, DLL relock, and power-down or self-refresh from their second CK, then follows software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      odt_q <= 1'b0;
    end else if (step_w) begin
      odt_q <= ctrl_w[ddrcke_pkg::CTRL_ODT_BIT] && rd_ok_w;
    end
  end

  assign stat_w = {22'h0, wr_clamp_w, pd_act_q, idle_w, wr_ok_w, rd_ok_w, init_done_q, st_q};

  assign ck_o = ck_q;
  assign reset_n_o = reset_n_q;
  assign cke_o = cke_q;
  assign {cs_n_o, ras_n_o, cas_n_o, we_n_o} = cmd_q;
  assign ba_o = ba_q;
  assign addr_o = addr_q;
  assign odt_o = odt_q;
  assign init_done_o = init_done_q;
  assign idle_o = idle_w;

  // Helper counters for the checks below
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_low_q <= 32'h0000_0000;
      post_rst_q <= 32'h0000_0000;
      last_mr_q <= 3'h7;
    end else begin
      if (!reset_n_q && rst_low_q != 32'hffff_ffff) rst_low_q <= rst_low_q + 32'h0000_0001;
      if (reset_n_q && post_rst_q != 32'hffff_ffff) post_rst_q <= post_rst_q + 32'h0000_0001;
      // An MRS stands a whole CK; record it only on its last clk cycle
      if (cmd_q == ddrcke_pkg::CMD_MRS && step_w) last_mr_q <= ba_q;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_cke_edge_cmd: assert property ((cke_q != cke_prev_q) |->
    (cmd_q == ddrcke_pkg::CMD_NOP || cmd_q == ddrcke_pkg::CMD_DES ||
     cmd_q == ddrcke_pkg::CMD_REF))
    else $error("CKE changed with a command other than NOP, deselect or refresh");

  a_sr_entry_idle: assert property ((!cke_q && cke_prev_q && cmd_q == ddrcke_pkg::CMD_REF) |->
    ($past(banks_idle_i) && !$past(burst_busy_i)))
    else $error("Self-refresh entered with banks open or a burst running");

  a_cke_min_pulse: assert property ((cke_q != cke_prev_q) |->
    (32'(cke_age_q) >= ddrcke_pkg::CKE_AGE_MIN))
    else $error("CKE changed before its minimum pulse time");

  a_srx_quiet: assert property ($fell(srx_pulse_q) |->
    (cmd_q == ddrcke_pkg::CMD_NOP || cmd_q == ddrcke_pkg::CMD_DES) [*8])
    else $error("Command issued during self-refresh exit time");

  a_srx_write_wait: assert property ($rose(srx_pulse_q) |=> !wr_ok_w [*8])
    else $error("Writes allowed too soon after self-refresh exit");

  a_reset_hold: assert property ($rose(reset_n_q) |->
    ($past(rst_low_q) >= RST_CYC - 1 && !cke_q))
    else $error("Reset released too early or with CKE high");

  a_cke_first_rise: assert property (($rose(cke_q) && !init_done_q) |->
    ($past(post_rst_q) >= WAIT_CYC))
    else $error("CKE raised before the post-reset wait");

  a_cke_init_high: assert property ((!init_done_q && $past(cke_q)) |-> cke_q)
    else $error("CKE dropped during initialization");

  a_odt_init_low: assert property (!init_done_q |-> !odt_q)
    else $error("ODT not held low during initialization");

  a_mrs_order: assert property ((cmd_q == ddrcke_pkg::CMD_MRS && !init_done_q) |->
    ((ba_q == ddrcke_pkg::BA_MR2 && last_mr_q == 3'h7) ||
     (ba_q == ddrcke_pkg::BA_MR3 && last_mr_q == ddrcke_pkg::BA_MR2) ||
     (ba_q == ddrcke_pkg::BA_MR1 && last_mr_q == ddrcke_pkg::BA_MR3 && !addr_q[0]) ||
     (ba_q == ddrcke_pkg::BA_MR0 && last_mr_q == ddrcke_pkg::BA_MR1)))
    else $error("Mode register load order broken");

  a_mr0_bits: assert property ((cmd_q == ddrcke_pkg::CMD_MRS && ba_q == 3'h0) |->
    (addr_q[8] && !addr_q[13]))
    else $error("MR0 load without DLL reset or with reserved bit set");
endmodule

// *** dv/ddrcke_dev_model.sv ***
// Behavioural DDR3 device model watching the command pins
`timescale 1ns/1ps
module ddrcke_dev_model #(
  parameter int MIN_RST_CK = 4,
  parameter int MIN_WAIT_CK = 4
) (
  input wire logic ck_i,
  input wire logic reset_n_i,
  input wire logic cke_i,
  input wire logic [3:0] cmd_i,
  input wire logic [2:0] ba_i,
  input wire logic [13:0] addr_i,
  input wire logic odt_i,
  input wire logic banks_idle_i,
  output int err_o,
  output logic sr_o,
  output logic pd_o,
  output logic pd_act_o,
  output logic term_o,
  output logic [3:0][13:0] mr_o
);
  localparam logic [3:0][2:0] ORD = {ddrcke_pkg::BA_MR0, ddrcke_pkg::BA_MR1,
    ddrcke_pkg::BA_MR3, ddrcke_pkg::BA_MR2};
  logic cke_q = 1'b0;
  logic up = 1'b0;
  logic quiet;
  int step = 0, ck_n = 0, rst_n_ck = 0, xs_n = 0, xpr = 0, age = 1000;
  initial begin
    err_o = 0;
    sr_o = 0;
    pd_o = 0;
    pd_act_o = 0;
  end
  assign quiet = cmd_i[3] | (cmd_i == ddrcke_pkg::CMD_NOP);
  assign term_o = reset_n_i & up & ~sr_o & odt_i;
  always @(posedge ck_i) begin
    if (!reset_n_i) begin
      rst_n_ck++;
      ck_n = 0;
      step = 0;
      up = 0;
      cke_q = 0;
    end else begin
      if (ck_n == 0 && rst_n_ck < MIN_RST_CK) err_o++;
      ck_n++;
      xpr++;
      age++;
      if (xs_n > 0) begin
        xs_n--;
        if (!quiet) err_o++;
      end
      if (cke_i !== cke_q) begin
        if (age < int'(ddrcke_pkg::TCKE_CK) - 1) err_o++;
        age = 0;
        if (!cke_i && step < 5) err_o++;
        if (!cke_i && cmd_i == ddrcke_pkg::CMD_REF) begin
          if (!banks_idle_i) err_o++;
          sr_o = 1;
        end else if (!quiet) begin
          err_o++;
        end else if (!cke_i) begin
          pd_o = 1;
          pd_act_o = ~banks_idle_i;
        end else begin
          if (sr_o) xs_n = ddrcke_pkg::XS_CK - 1;
          sr_o = 0;
          pd_o = 0;
          if (!up && ck_n < MIN_WAIT_CK) err_o++;
          if (!up) xpr = 0;
          up = 1;
        end
      end
      if (cke_i && cke_q && cmd_i == ddrcke_pkg::CMD_MRS) begin
        if (xpr < ddrcke_pkg::XPR_CK || step > 3 || ba_i !== ORD[step[1:0]]) err_o++;
        if (ba_i == ddrcke_pkg::BA_MR1 && addr_i[0]) err_o++;
        if (ba_i == ddrcke_pkg::BA_MR0 && (!addr_i[8] || addr_i[13])) err_o++;
        mr_o[ba_i[1:0]] = addr_i;
        step++;
      end
      if (cke_i && cmd_i == ddrcke_pkg::CMD_ZQCL) begin
        if (step != 4 || !addr_i[10]) err_o++;
        step = 5;
      end
      cke_q = cke_i;
    end
  end
endmodule

// *** dv/ddrcke_ctrl_tb_top.sv ***
// Self-checking bench of the DDR3 power-state and init sequencer
`timescale 1ns/1ps
module ddrcke_ctrl_tb_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0000_0000, rd, wb_dat_o;
  logic wb_ack_o, banks_idle = 1, busy = 0, ref_due = 0;
  logic ck_o, reset_n_o, cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, odt_o, init_done_o, idle_o;
  logic [2:0] ba_o;
  logic [13:0] addr_o;
  logic [3:0][13:0] mr;
  logic sr, pd, pd_act, term;
  int err, n_fail = 0, checked = 0, cyc_n = 0;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n++;
  ddrcke_ctrl #(.RST_CYC(40), .WAIT_CYC(40)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .banks_idle_i(banks_idle),
    .burst_busy_i(busy), .ref_due_i(ref_due), .ck_o(ck_o), .reset_n_o(reset_n_o),
    .cke_o(cke_o), .cs_n_o(cs_n_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o),
    .ba_o(ba_o), .addr_o(addr_o), .odt_o(odt_o), .init_done_o(init_done_o), .idle_o(idle_o));
  ddrcke_dev_model MEM (.ck_i(ck_o), .reset_n_i(reset_n_o), .cke_i(cke_o),
    .cmd_i({cs_n_o, ras_n_o, cas_n_o, we_n_o}), .ba_i(ba_o), .addr_i(addr_o), .odt_i(odt_o),
    .banks_idle_i(banks_idle), .err_o(err), .sr_o(sr), .pd_o(pd), .pd_act_o(pd_act),
    .term_o(term), .mr_o(mr));
  task automatic print_verdict();
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bail();
    n_fail++;
    $display("[ERR] %0t wait ran out", $time);
    print_verdict();
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 50) bail();
    rd = wb_dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic wt(input int s, input logic v, input int lim);
    int i;
    logic cur;
    for (i = 0; i < lim; i++) begin
      @(posedge clk_i);
      cur = (s == 0) ? init_done_o : (s == 1) ? pd : (s == 2) ? sr : idle_o;
      if (cur === v) break;
    end
    if (i == lim) bail();
  endtask
  task automatic t_regs_init();
    wb(0, ddrcke_pkg::REG_CTRL, 0);
    chk(rd, ddrcke_pkg::CTRL_RST);
    wb(0, ddrcke_pkg::REG_MR01, 0);
    chk(rd, ddrcke_pkg::MR01_RST);
    wb(0, ddrcke_pkg::REG_MR23, 0);
    chk(rd, ddrcke_pkg::MR23_RST);
    wb(1, 8'h10, 32'hffff_ffff);
    wb(0, 8'h10, 0);
    chk(rd, 32'h0000_0000);
    // A0 set in MR1 and A13 set, A8 clear in MR0 must be corrected on the pins
    wb(1, ddrcke_pkg::REG_MR01, 32'h0045_2020);
    wb(1, ddrcke_pkg::REG_MR23, 32'h0010_0008);
    wt(0, 1, 20000);
    chk(mr[2], 14'h0008);
    chk(mr[3], 14'h0010);
    chk(mr[1], 14'h0044);
    chk(mr[0], 14'h0120);
    wb(0, ddrcke_pkg::REG_STAT, 0);
    chk(rd & 32'h0000_009f, 32'h0000_0099);
    chk(err, 0);
  endtask
  task automatic t_pd();
    banks_idle <= 0;
    wb(1, ddrcke_pkg::REG_CTRL, 32'h0000_0001);
    wt(1, 1, 400);
    chk(pd_act, 1);
    wb(0, ddrcke_pkg::REG_STAT, 0);
    chk(rd & 32'h0000_018f, 32'h0000_010a);
    ref_due <= 1;
    wt(1, 0, 400);
    wb(1, ddrcke_pkg::REG_CTRL, 0);
    ref_due <= 0;
    banks_idle <= 1;
    wt(3, 1, 400);
    chk(err, 0);
  endtask
  task automatic t_sr();
    int t0;
    banks_idle <= 0;
    busy <= 1;
    wb(1, ddrcke_pkg::REG_CTRL, 32'h0000_0006);
    repeat (200) @(posedge clk_i);
    chk(sr, 0);
    banks_idle <= 1;
    busy <= 0;
    wt(2, 1, 400);
    repeat (40) @(posedge clk_i);
    chk({odt_o, term}, 2'b00);
    wb(1, ddrcke_pkg::REG_CTRL, 32'h0000_0004);
    wt(2, 0, 400);
    t0 = cyc_n;
    rd = 0;
    while (rd[6] !== 1'b1 && cyc_n - t0 < 6000) wb(0, ddrcke_pkg::REG_STAT, 0);
    chk(cyc_n - t0 >= 4088 && cyc_n - t0 <= 4200, 1);
    chk(rd[5], 1'b1);
    chk(err, 0);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    t_regs_init();
    t_pd();
    t_sr();
    print_verdict();
  end
  initial begin
    #400000;
    bail();
  end
endmodule
